// File: core/laser_current_control_supervisor.sv
// Notes on behaviour
// [R1] Setpoints held in 0.1 A steps
// [R2] Configurable limit caps every setpoint
// [R3] Status bit 1 picks external source
// [R4] Source change accepted only while disabled
// [R5] Status bit 7 picks zero-based scaling
// [R6] Zero-based: below minimum disables output
// [R7] External setpoint is 10-bit sample
// [R8] Shut down above 80 degrees
// [R9] Overtemperature latched into error register
// [R10] Enable low-then-high clears latched fault
// [R11] Self test gates enabling at power-up
// [R12] Ready high after self test passes
// [R13] Test nominal 5 s, max 15 s
// [R14] Settings kept, or defaults at power-up
// [R15] Host attach leaves settings untouched
// [R16] Enable input high turns output on
// [R17] Any error disables output, drops ready; below-minimum disables output but leaves ready high
// [R18] Serial link disables hand-held port
// [R19] PI loop with adjustable gains
// [R20] Gain defaults 200 and 100
// [R21] Software enable when external option off
// [R22] Ready low during test or fault
// [R23] Clamp after selection and scaling
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module laser_current_control_supervisor
	import laser_supervisor_pkg::*;
#(
	parameter int SELFTEST_NOM = SELFTEST_NOM_CYC,
	parameter int SELFTEST_MAX = SELFTEST_MAX_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_enable,
	input wire logic [9:0] i_ext_sample,
	input wire logic [7:0] i_board_temp,
	input wire logic [CUR_W-1:0] i_meas_current,
	input wire logic i_safety_ok,
	input wire logic i_serial_link,
	input wire settings_t i_nv_last,
	input wire settings_t i_nv_defaults,
	output settings_t o_nv_last,
	output logic o_nv_save_defaults,
	output logic o_handheld_en,
	output logic o_output_en,
	output logic o_driver_ready,
	output logic [15:0] o_drive
);
	initial begin
		if (SELFTEST_NOM < 1 || SELFTEST_MAX < SELFTEST_NOM) begin
			$error("self test counts out of range");
		end
	end

	function automatic logic [CUR_W-1:0] scale_fn(input logic [9:0] sample,
			input logic [CUR_W-1:0] span);
		logic [20:0] p;
		logic [21:0] q;
		p = 21'(sample) * 21'(span);
		// Close to p/1023; full scale reaches one step below the whole span
		q = 22'(p) + 22'(p >> 10);
		return CUR_W'(q >> 10);
	endfunction : scale_fn

	function automatic logic [31:0] merge_fn(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction : merge_fn

	settings_t set_q;
	test_state_t test_q;
	logic [31:0] test_cnt_q, w_data_q, rdata_q, wr_old, wr_val, rd_val;
	logic overtemp_q, seen_low_q, out_en_q, aw_have_q, w_have_q, bvalid_q, rvalid_q;
	logic save_q, handheld_q, tick, wr_go, rd_ok, wr_ok, req, hot, ready, below_min;
	logic [7:0] aw_addr_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [4:0] div_q;
	logic signed [31:0] integ_q;
	logic [15:0] drive_q;
	logic [CUR_W-1:0] target_q, ext_cur, sel_cur, base, span, wr_cur;

	assign req = set_q.ext_en_opt ? i_enable : set_q.sw_enable; // [R16] [R21]
	assign hot = i_board_temp > TEMP_LIMIT_C; // [R8]
	assign ready = (test_q == TEST_PASS) && !overtemp_q; // [R12] [R22] [R17]

	// External setpoint scaling and clamp
	always_comb begin
		base = set_q.zero_scale ? '0 : CUR_MIN; // [R5]
		span = (set_q.limit > base) ? set_q.limit - base : '0;
		ext_cur = CUR_W'(base + scale_fn(i_ext_sample, span)); // [R7]
		below_min = set_q.ext_src && set_q.zero_scale && (ext_cur < CUR_MIN); // [R6]
		sel_cur = set_q.ext_src ? ext_cur : set_q.setpoint; // [R3]
		if (sel_cur > set_q.limit) sel_cur = set_q.limit; // [R2] [R23]
	end

	// Power-up load and self test
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			test_q <= TEST_LOAD;
			test_cnt_q <= '0;
		end else begin
			unique case (test_q)
				TEST_LOAD: test_q <= TEST_RUN; // [R11]
				TEST_RUN: begin
					test_cnt_q <= test_cnt_q + 32'h00000001;
					// Pass at the nominal mark; a failing check may still recover late
					if (test_cnt_q >= 32'(SELFTEST_NOM - 1) && i_safety_ok) begin
						test_q <= TEST_PASS; // [R13]
					end else if (test_cnt_q >= 32'(SELFTEST_MAX - 1)) begin
						test_q <= TEST_FAIL; // [R13]
					end
				end
				TEST_PASS, TEST_FAIL: test_q <= test_q;
			endcase
		end
	end

	// Overtemperature latch and toggle clear
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			overtemp_q <= 1'b0;
			seen_low_q <= 1'b0;
		end else if (hot) begin
			overtemp_q <= 1'b1; // [R9]
			seen_low_q <= 1'b0;
		end else if (overtemp_q) begin
			if (!req) seen_low_q <= 1'b1; // [R10]
			else if (seen_low_q) begin
				overtemp_q <= 1'b0; // [R10]
				seen_low_q <= 1'b0;
			end
		end
	end

	// Output gate and clamped target
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			out_en_q <= 1'b0;
			target_q <= '0;
		end else begin
			out_en_q <= ready && req && !hot && !below_min; // [R11] [R17] [R6] [R16]
			target_q <= sel_cur; // [R1] [R23]
		end
	end

	// Control loop update rate
	assign tick = (div_q == 5'(LOOP_DIV - 1));
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			div_q <= '0;
		end else begin
			div_q <= tick ? '0 : div_q + 5'h01;
		end
	end

	// PI regulator; integrator cleared while off to avoid a kick on enable
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		logic signed [12:0] err;
		logic signed [31:0] p_term;
		logic signed [31:0] i_next;
		logic signed [31:0] sum;
		if (i_reset) begin
			integ_q <= '0;
			drive_q <= '0;
		end else if (!out_en_q) begin
			integ_q <= '0;
			drive_q <= '0;
		end else if (tick) begin
			err = $signed({2'b00, target_q}) - $signed({2'b00, i_meas_current});
			p_term = $signed({16'h0000, set_q.pgain}) * 32'(err); // [R19]
			i_next = integ_q + $signed({16'h0000, set_q.igain}) * 32'(err); // [R19]
			i_next = (i_next > 32'sh3FFFFFFF) ? 32'sh3FFFFFFF : i_next;
			i_next = (i_next < -32'sh3FFFFFFF) ? -32'sh3FFFFFFF : i_next;
			integ_q <= i_next;
			sum = (p_term >>> 1) + (i_next >>> 1);
			sum = sum >>> (PI_SHIFT - 1);
			drive_q <= (sum < 0) ? 16'h0000 : (sum > 32'sh0000FFFF) ? 16'hFFFF : sum[15:0];
		end
	end

	// AXI4-Lite write channel capture
	assign o_awready = !aw_have_q && !bvalid_q;
	assign o_wready = !w_have_q && !bvalid_q;
	assign wr_go = aw_have_q && w_have_q && !bvalid_q;
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= i_wdata;
				w_strb_q <= i_wstrb;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && i_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_ok = 1'b1;
		wr_old = '0;
		unique case (aw_addr_q)
			ADDR_STATUS: begin
				wr_old[ST_SW_EN] = set_q.sw_enable;
				wr_old[ST_EXT_SRC] = set_q.ext_src;
				wr_old[ST_EXT_EN_OPT] = set_q.ext_en_opt;
				wr_old[ST_DEF_PWRON] = set_q.def_pwron;
				wr_old[ST_ZERO_SCALE] = set_q.zero_scale;
			end
			ADDR_SETPOINT: wr_old = 32'(set_q.setpoint);
			ADDR_LIMIT: wr_old = 32'(set_q.limit);
			ADDR_PGAIN: wr_old = 32'(set_q.pgain);
			ADDR_IGAIN: wr_old = 32'(set_q.igain);
			ADDR_CMD: wr_old = '0;
			default: wr_ok = 1'b0;
		endcase
		wr_val = merge_fn(wr_old, w_data_q, w_strb_q);
		wr_cur = (wr_val[31:CUR_W] != '0 || wr_val[CUR_W-1:0] > CUR_MAX) ?
			CUR_MAX : wr_val[CUR_W-1:0];
	end

	// Settings; link attach events never touch them
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			set_q <= RST_SETTINGS; // [R20]
			save_q <= 1'b0;
		end else begin
			save_q <= 1'b0;
			if (test_q == TEST_LOAD) begin
				set_q <= i_nv_last.def_pwron ? i_nv_defaults : i_nv_last; // [R14]
				set_q.sw_enable <= 1'b0;
			end else if (wr_go && wr_ok) begin // [R15]
				unique case (aw_addr_q)
					ADDR_STATUS: begin
						set_q.sw_enable <= wr_val[ST_SW_EN];
						if (!out_en_q) set_q.ext_src <= wr_val[ST_EXT_SRC]; // [R4] [R3]
						set_q.ext_en_opt <= wr_val[ST_EXT_EN_OPT];
						set_q.def_pwron <= wr_val[ST_DEF_PWRON];
						set_q.zero_scale <= wr_val[ST_ZERO_SCALE]; // [R5]
					end
					ADDR_SETPOINT: set_q.setpoint <= wr_cur; // [R1]
					ADDR_LIMIT: set_q.limit <= wr_cur; // [R2]
					ADDR_PGAIN: set_q.pgain <= wr_val[15:0]; // [R19]
					ADDR_IGAIN: set_q.igain <= wr_val[15:0]; // [R19]
					ADDR_CMD: begin
						// Loading defaults forces a fresh software enable
						if (wr_val[CMD_LOAD_DEF]) begin
							set_q <= i_nv_defaults;
							set_q.sw_enable <= 1'b0;
							// Source stays put while the output may still be on
							if (out_en_q) set_q.ext_src <= set_q.ext_src; // [R4]
						end
						save_q <= wr_val[CMD_SAVE_DEF];
					end
					default: set_q <= set_q;
				endcase
			end
		end
	end

	// AXI4-Lite read channel
	always_comb begin
		rd_ok = 1'b1;
		rd_val = '0;
		unique case (i_araddr)
			ADDR_STATUS: begin
				rd_val[ST_SW_EN] = set_q.sw_enable;
				rd_val[ST_EXT_SRC] = set_q.ext_src;
				rd_val[ST_EXT_EN_OPT] = set_q.ext_en_opt;
				rd_val[ST_DEF_PWRON] = set_q.def_pwron;
				rd_val[ST_ZERO_SCALE] = set_q.zero_scale;
				rd_val[ST_OUT_ON] = out_en_q;
				rd_val[ST_READY] = ready;
				rd_val[ST_TEST_DONE] = test_q[1];
			end
			ADDR_SETPOINT: rd_val = 32'(set_q.setpoint);
			ADDR_LIMIT: rd_val = 32'(set_q.limit);
			ADDR_PGAIN: rd_val = 32'(set_q.pgain);
			ADDR_IGAIN: rd_val = 32'(set_q.igain);
			ADDR_ERROR: begin
				rd_val[ERR_OVERTEMP] = overtemp_q; // [R9]
				rd_val[ERR_SELFTEST] = (test_q == TEST_FAIL);
				rd_val[ERR_BELOW_MIN] = below_min;
			end
			ADDR_TARGET: rd_val = 32'(target_q);
			ADDR_TEMP: rd_val = 32'(i_board_temp);
			ADDR_CMD: rd_val = '0;
			default: rd_ok = 1'b0;
		endcase
	end

	assign o_arready = !rvalid_q;
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_val;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && i_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Hand-held port gate
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			handheld_q <= 1'b1;
		end else begin
			handheld_q <= !i_serial_link; // [R18]
		end
	end

	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;
	assign o_nv_last = set_q; // [R14]
	assign o_nv_save_defaults = save_q;
	assign o_handheld_en = handheld_q;
	assign o_output_en = out_en_q;
	assign o_driver_ready = ready; // [R12]
	assign o_drive = drive_q;
endmodule : laser_current_control_supervisor
`default_nettype wire

// File: include/laser_supervisor_pkg.sv
package laser_supervisor_pkg;
	// Bus map, byte addresses
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_SETPOINT = 8'h04;
	localparam logic [7:0] ADDR_LIMIT = 8'h08;
	localparam logic [7:0] ADDR_PGAIN = 8'h0C;
	localparam logic [7:0] ADDR_IGAIN = 8'h10;
	localparam logic [7:0] ADDR_ERROR = 8'h14;
	localparam logic [7:0] ADDR_TARGET = 8'h18;
	localparam logic [7:0] ADDR_TEMP = 8'h1C;
	localparam logic [7:0] ADDR_CMD = 8'h20;
	// laser_status_reg fields
	localparam int ST_SW_EN = 0;
	localparam int ST_EXT_SRC = 1;
	localparam int ST_EXT_EN_OPT = 2;
	localparam int ST_DEF_PWRON = 3;
	localparam int ST_ZERO_SCALE = 7;
	localparam int ST_OUT_ON = 8;
	localparam int ST_READY = 9;
	localparam int ST_TEST_DONE = 10;
	// Error register and command fields
	localparam int ERR_OVERTEMP = 0;
	localparam int ERR_SELFTEST = 1;
	localparam int ERR_BELOW_MIN = 2;
	localparam int CMD_LOAD_DEF = 0;
	localparam int CMD_SAVE_DEF = 1;
	// Currents in 0.1 A units
	localparam int CUR_W = 11;
	localparam logic [CUR_W-1:0] CUR_MIN = 11'h032;
	localparam logic [CUR_W-1:0] CUR_MAX = 11'h514;
	localparam logic [CUR_W-1:0] RST_SETPOINT = 11'h032;
	localparam logic [15:0] RST_PGAIN = 16'h00C8;
	localparam logic [15:0] RST_IGAIN = 16'h0064;
	localparam logic [7:0] TEMP_LIMIT_C = 8'h50;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing
	localparam longint CLK_HZ = 25000000;
	localparam longint SELFTEST_NOM_S = 5;
	localparam longint SELFTEST_MAX_S = 15;
	localparam int SELFTEST_NOM_CYC = int'(SELFTEST_NOM_S * CLK_HZ);
	localparam int SELFTEST_MAX_CYC = int'(SELFTEST_MAX_S * CLK_HZ);
	localparam int LOOP_DIV = 25;
	localparam int PI_SHIFT = 8;

	typedef struct packed {
		logic sw_enable;
		logic ext_src;
		logic ext_en_opt;
		logic def_pwron;
		logic zero_scale;
		logic [CUR_W-1:0] setpoint;
		logic [CUR_W-1:0] limit;
		logic [15:0] pgain;
		logic [15:0] igain;
	} settings_t;

	localparam settings_t RST_SETTINGS = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
		RST_SETPOINT, CUR_MAX, RST_PGAIN, RST_IGAIN};

	typedef enum logic [1:0] {
		TEST_LOAD = 2'b00,
		TEST_RUN = 2'b01,
		TEST_PASS = 2'b10,
		TEST_FAIL = 2'b11
	} test_state_t;
endpackage : laser_supervisor_pkg

// File: tb/supervisor_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module supervisor_checker
	import laser_supervisor_pkg::*;
#(
	parameter int SELFTEST_NOM = 20,
	parameter int SELFTEST_MAX = 60
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_enable,
	input wire logic [7:0] i_board_temp,
	input wire logic [9:0] i_ext_sample,
	input wire logic i_serial_link,
	input wire logic i_arvalid,
	input wire logic i_bready,
	input wire logic o_arready,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic o_rvalid,
	input wire logic o_output_en,
	input wire logic o_driver_ready,
	input wire logic o_handheld_en,
	input wire logic [15:0] o_drive,
	input wire settings_t o_nv_last
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	out_needs_ready_a: assert property (o_output_en |-> $past(o_driver_ready))
		else $error("output on without ready");
	hot_shutdown_a: assert property (i_board_temp > TEMP_LIMIT_C |=> !o_output_en && !o_driver_ready)
		else $error("no shutdown when hot");
	fault_latch_a: assert property ((i_enable && o_nv_last.ext_en_opt) [*2] ##0
		$fell(o_driver_ready) ##1 i_enable [*3] |-> !o_driver_ready)
		else $error("fault cleared without enable toggle");
	ready_rise_a: assert property ($rose(o_driver_ready) |-> $past(i_board_temp) <= TEMP_LIMIT_C)
		else $error("ready rose while hot");
	drive_off_a: assert property (!o_output_en && $past(!o_output_en) |-> o_drive == 16'h0000)
		else $error("drive not cleared while off");
	handheld_off_a: assert property (i_serial_link |=> !o_handheld_en)
		else $error("hand-held port left on");
	below_min_a: assert property ((o_nv_last.zero_scale && o_nv_last.ext_src &&
		i_ext_sample < 10'h010) [*3] |=> !o_output_en)
		else $error("output on below minimum");
	src_locked_a: assert property (o_output_en && $past(o_output_en) |-> $stable(o_nv_last.ext_src))
		else $error("source changed while enabled");
	bvalid_drop_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("write response repeated");
	read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read answer late");
	cover property ($fell(o_driver_ready));
	cover property ($rose(o_output_en));
	cover property (o_bvalid && o_bresp == RESP_SLVERR);
endmodule : supervisor_checker
bind laser_current_control_supervisor supervisor_checker #(.SELFTEST_NOM(SELFTEST_NOM),
	.SELFTEST_MAX(SELFTEST_MAX)) checker_i (.i_ref_clk, .i_reset, .i_enable, .i_board_temp,
	.i_ext_sample, .i_serial_link, .i_arvalid, .i_bready, .o_arready, .o_bvalid, .o_bresp,
	.o_rvalid, .o_output_en, .o_driver_ready, .o_handheld_en, .o_drive, .o_nv_last);
`default_nettype wire

// File: tb/ext_controller_model.sv
`timescale 1ns/1ns
`default_nettype none
module ext_controller_model
	import laser_supervisor_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_want_on,
	input wire logic [7:0] i_temp,
	input wire logic [9:0] i_sample,
	input wire logic [15:0] i_drive,
	output logic o_enable,
	output logic [7:0] o_board_temp,
	output logic [9:0] o_ext_sample,
	output logic [CUR_W-1:0] o_meas_current
);
	// Clearing a fault means the bench drops i_want_on, then raises it
	always_ff @(posedge i_ref_clk) begin
		o_enable <= i_want_on;
		o_board_temp <= i_temp;
		o_ext_sample <= i_sample;
		o_meas_current <= i_drive[15:5]; // Crude plant: current follows drive
	end
endmodule : ext_controller_model
`default_nettype wire

// File: tb/laser_current_control_supervisor_bench.sv
`timescale 1ns/1ns
`default_nettype none
module laser_current_control_supervisor_bench;
	import laser_supervisor_pkg::*;
	localparam int NOM = 20;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} row_t;
	logic ref_clk, reset, awvalid, wvalid, bready, arvalid, rready, want_on, safety_ok;
	logic awready, wready, bvalid, arready, rvalid, nv_save, handheld_en, output_en;
	logic driver_ready, enable, serial_link;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] wdata, rdata, got;
	logic [7:0] awaddr, araddr, temp, board_temp;
	logic [9:0] sample, ext_sample;
	logic [CUR_W-1:0] meas;
	logic [15:0] drive;
	settings_t nv_last, nv_def, nv_out, exp_s;
	int errors, checks_done, n;
	row_t rows[6];
	laser_current_control_supervisor #(.SELFTEST_NOM(NOM), .SELFTEST_MAX(60)) DUT (
		.i_ref_clk(ref_clk), .i_reset(reset), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
		.o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_enable(enable),
		.i_ext_sample(ext_sample), .i_board_temp(board_temp), .i_meas_current(meas),
		.i_safety_ok(safety_ok), .i_serial_link(serial_link), .i_nv_last(nv_last),
		.i_nv_defaults(nv_def), .o_nv_last(nv_out), .o_nv_save_defaults(nv_save),
		.o_handheld_en(handheld_en), .o_output_en(output_en),
		.o_driver_ready(driver_ready), .o_drive(drive));
	ext_controller_model partner (.i_ref_clk(ref_clk), .i_want_on(want_on), .i_temp(temp),
		.i_sample(sample), .i_drive(drive), .o_enable(enable), .o_board_temp(board_temp),
		.o_ext_sample(ext_sample), .o_meas_current(meas));
	initial begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : cyc
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic chks(input settings_t g, input settings_t e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t settings %h want %h", $time, g, e);
		end
	endtask : chks
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		r = 2'h1;
		forever begin
			@(posedge ref_clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) begin
				r = bresp;
				bready <= 0;
				break;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(posedge ref_clk);
			if (arready) arvalid <= 0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 0;
				break;
			end
		end
	endtask : rd
	task automatic results();
		if (errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	initial begin
		cyc(5000); // Whole run is well under a thousand cycles
		errors++;
		results();
	end
	initial begin
		{reset, awvalid, wvalid, bready, arvalid, rready} = 6'h21;
		{awaddr, araddr, wdata, sample, serial_link} = '0;
		{want_on, safety_ok, temp} = {2'b11, 8'h19};
		nv_last = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 11'h0C8, 11'h3E8, 16'h0011, 16'h0022};
		nv_def = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 11'h064, 11'h200, 16'h0033, 16'h0044};
		rows[0] = '{1'b1, ADDR_SETPOINT, 32'h7D0, 32'h514, RESP_OKAY};
		rows[1] = '{1'b1, ADDR_LIMIT, 32'h100, 32'h100, RESP_OKAY};
		rows[2] = '{1'b1, ADDR_PGAIN, 32'h1234, 32'h1234, RESP_OKAY};
		rows[3] = '{1'b1, ADDR_IGAIN, 32'h55, 32'h55, RESP_OKAY};
		rows[4] = '{1'b0, ADDR_TARGET, 32'h0, 32'h100, RESP_OKAY};
		rows[5] = '{1'b1, 8'h40, 32'h1, 32'h0, RESP_SLVERR};
		cyc(6);
		chk(32'(nv_out.pgain), 32'(RST_PGAIN));
		chk(32'(nv_out.igain), 32'(RST_IGAIN));
		reset <= 0;
		exp_s = nv_last;
		exp_s.sw_enable = 0;
		cyc(2);
		chks(nv_out, exp_s);
		chk(32'({output_en, driver_ready}), 32'h0);
		n = 2;
		while (driver_ready !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk(32'(n >= NOM - 2 && n <= NOM + 2), 32'h1);
		cyc(2);
		chk(32'(output_en), 32'h1);
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].a, rows[i].d, resp);
			if (rows[i].wr) chk(32'(resp), 32'(rows[i].r));
			rd(rows[i].a, got, resp);
			chk(got, rows[i].e);
			chk(32'(resp), 32'(rows[i].r));
		end
		wr(ADDR_STATUS, 32'h86, resp);
		rd(ADDR_STATUS, got, resp);
		chk(got & 32'h86, 32'h84);
		want_on <= 0;
		cyc(3);
		wr(ADDR_STATUS, 32'h86, resp);
		rd(ADDR_STATUS, got, resp);
		chk(got & 32'h86, 32'h86);
		sample <= 10'h200;
		want_on <= 1;
		cyc(4);
		rd(ADDR_TARGET, got, resp);
		chk(got, 32'h80);
		wr(ADDR_STATUS, 32'h06, resp);
		rd(ADDR_TARGET, got, resp);
		chk(got, 32'h99);
		wr(ADDR_STATUS, 32'h86, resp);
		sample <= 10'h00F;
		cyc(5);
		chk(32'(output_en), 32'h0);
		rd(ADDR_ERROR, got, resp);
		chk(got & 32'h4, 32'h4);
		sample <= 10'h200;
		cyc(5);
		chk(32'(output_en), 32'h1);
		temp <= 8'h51;
		cyc(3);
		chk(32'({output_en, driver_ready}), 32'h0);
		temp <= TEMP_LIMIT_C;
		cyc(5);
		chk(32'(driver_ready), 32'h0);
		rd(ADDR_ERROR, got, resp);
		chk(got & 32'h1, 32'h1);
		want_on <= 0;
		cyc(3);
		want_on <= 1;
		cyc(4);
		chk(32'({driver_ready, output_en}), 32'h3);
		serial_link <= 1;
		cyc(2);
		chk(32'(handheld_en), 32'h0);
		exp_s = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 11'h514, 11'h100, 16'h1234, 16'h0055};
		chks(nv_out, exp_s);
		wr(ADDR_STATUS, 32'h00, resp);
		want_on <= 0;
		cyc(3);
		chk(32'(output_en), 32'h0);
		wr(ADDR_STATUS, 32'h01, resp);
		cyc(3);
		chk(32'(output_en), 32'h1);
		wr(ADDR_CMD, 32'h3, resp);
		chk(32'(nv_save), 32'h1);
		chks(nv_out, nv_def);
		nv_last.def_pwron <= 1;
		reset <= 1;
		cyc(2);
		reset <= 0;
		cyc(2);
		chks(nv_out, nv_def);
		safety_ok <= 0;
		reset <= 1;
		cyc(2);
		reset <= 0;
		cyc(40);
		chk(32'({driver_ready, output_en}), 32'h0);
		cyc(30);
		chk(32'(driver_ready), 32'h0);
		rd(ADDR_ERROR, got, resp);
		chk(got & 32'h3, 32'h2);
		results();
	end
endmodule : laser_current_control_supervisor_bench
`default_nettype wire
